// file: core/cbct_pkg.sv
package cbct_pkg;

    // ********************************************************************
    // Cycle adjustment constants
    // ********************************************************************
    localparam logic [3:0] CBCT_ONE_CYCLE      = 4'h1;
    localparam logic [3:0] CBCT_WAIT_HOLD      = 4'h2;
    localparam logic [7:0] CBCT_DL_ZERO        = 8'h00;
    localparam logic [3:0] CBCT_BASE_RESET     = 4'h0;
    localparam int         CBCT_CLK_NS         = 50;

    // ********************************************************************
    // Instruction classes offered by the decoder
    // ********************************************************************
    typedef enum logic [3:0] {
        CBCT_CLS_OTHER,
        CBCT_CLS_IMMEDIATE,
        CBCT_CLS_DIRECT,
        CBCT_CLS_ABS_INDEXED,
        CBCT_CLS_BRANCH,
        CBCT_CLS_INTERRUPT,
        CBCT_CLS_STATUS_OP,
        CBCT_CLS_BLOCK_MOVE
    } cbct_class_e;

    // Decoded instruction description handed in at start
    typedef struct packed {
        cbct_class_e cls;
        logic [3:0]  base_cycles;
        logic        uses_acc;
        logic        uses_index;
        logic        is_write;
        logic        page_cross;
        logic        branch_taken;
        logic [1:0]  abort_cycle;
    } cbct_instr_s;

    // Status/bank values committed after the abortable window
    typedef struct packed {
        logic [7:0] status;
        logic [7:0] program_bank_reg;
        logic [7:0] data_bank_reg;
    } cbct_commit_s;

endpackage

// file: core/cbct_cycle_timing.sv
`timescale 1ns/1ns
`default_nettype none
// Operation
// - 16-bit accumulator or index width adds a cycle, and an operand byte for immediate
// - Direct-page modes add one cycle when direct base low byte is nonzero
// - Abort cancels only up to the last abortable cycle, then commit state
// - Indexed absolute adds a cycle on page cross, write or 16-bit index
// - Taken branches take one cycle more than not taken
// - Emulation mode taken branch crossing a page adds one further cycle
// - Interrupt entry and return are one cycle shorter in emulation mode
// - Status bit set and clear ops take one cycle over base immediate
// - Interrupt during wait holds at cycle two for two more cycles
// - Read/write goes to read level on the first clock edge of reset, then stays there
module cbct_cycle_timing
    import cbct_pkg::*;
(
    input  wire logic         mclk_i,
    input  wire logic         rst_n_i,
    input  wire logic         start_i,
    input  wire cbct_instr_s  instr_i,
    input  wire logic         acc_width_8_i,
    input  wire logic         index_width_8_i,
    input  wire logic         emulation_i,
    input  wire logic [7:0]   direct_base_low_byte_i,
    input  wire logic         waiting_i,
    input  wire logic         abort_pin_i,
    input  wire logic         nmi_pin_i,
    input  wire logic         irq_pin_i,
    input  wire logic         write_cycle_i,
    input  wire cbct_commit_s new_state_i,
    output var  logic         busy_o,
    output var  logic         done_o,
    output var  logic         aborted_o,
    output var  logic         extra_byte_o,
    output var  logic         invalid_addr_o,
    output var  logic         read_write_o,
    output var  logic [4:0]   cycle_o,
    output var  logic [4:0]   total_o,
    output var  cbct_commit_s committed_o
);

    // ********************************************************************
    // Pin synchronisers
    // ********************************************************************
    // Abort and both interrupt pins come from off chip
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] next_sync1;
    logic [2:0] next_sync2;
    logic       abort_s;
    logic       int_s;

    always_comb begin
        next_sync1 = {abort_pin_i, nmi_pin_i, irq_pin_i};
        next_sync2 = sync1;
    end

    // Reset clears both stages so no stale request survives it
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
        end else begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
        end
    end

    assign abort_s = sync2[2];
    assign int_s   = sync2[1] | sync2[0];

    // ********************************************************************
    // Cycle count arithmetic
    // ********************************************************************
    // Adjustments computed combinationally from the decoded class
    // A zero interrupt base count would wrap in emulation; the decoder never offers one
    logic       wide;
    logic [4:0] adj_total;
    logic       adj_extra_byte;
    logic       adj_invalid;

    always_comb begin
        wide           = (instr_i.uses_acc & ~acc_width_8_i)
                       | (instr_i.uses_index & ~index_width_8_i);
        adj_total      = {1'b0, instr_i.base_cycles};
        adj_extra_byte = 1'b0;
        adj_invalid    = 1'b0;
        if (wide) begin
            adj_total = adj_total + 5'h01;
        end
        case (instr_i.cls)
            CBCT_CLS_IMMEDIATE: begin
                adj_extra_byte = wide;
            end
            CBCT_CLS_DIRECT: begin
                // A direct base off a page start costs one internal cycle
                if (direct_base_low_byte_i != CBCT_DL_ZERO) begin
                    adj_total = adj_total + 5'h01;
                end
            end
            CBCT_CLS_ABS_INDEXED: begin
                // Extra cycle only once, even when several causes coincide
                if (instr_i.page_cross | instr_i.is_write | ~index_width_8_i) begin
                    adj_total   = adj_total + 5'h01;
                    adj_invalid = index_width_8_i | emulation_i;
                end
            end
            CBCT_CLS_BRANCH: begin
                // Page cross costs extra only in emulation mode
                if (instr_i.branch_taken) begin
                    adj_total = adj_total + 5'h01;
                    if (emulation_i & instr_i.page_cross) begin
                        adj_total = adj_total + 5'h01;
                    end
                end
            end
            CBCT_CLS_INTERRUPT: begin
                // No program bank push or pull in emulation mode
                if (emulation_i) begin
                    adj_total = adj_total - 5'h01;
                end
            end
            CBCT_CLS_STATUS_OP: begin
                // Mask instructions pay one cycle over plain immediate
                adj_total = adj_total + 5'h01;
            end
            default: begin
                // Remaining classes run at their base count
                adj_total = adj_total;
            end
        endcase
    end

    // ********************************************************************
    // Sequencer
    // ********************************************************************
    typedef enum logic [1:0] {
        CBCT_IDLE,
        CBCT_RUN,
        CBCT_HOLD
    } cbct_state_e;

    // Sequencer position and counters
    cbct_state_e  state;
    cbct_state_e  next_state;
    logic [4:0]   cycle;
    logic [4:0]   next_cycle;
    logic [4:0]   total;
    logic [4:0]   next_total;
    logic [1:0]   abort_last;
    logic [1:0]   next_abort_last;
    logic [3:0]   hold_cnt;
    logic [3:0]   next_hold_cnt;
    // Registered copies of the outputs
    logic         busy;
    logic         next_busy;
    logic         done;
    logic         next_done;
    logic         aborted;
    logic         next_aborted;
    logic         xbyte;
    logic         next_xbyte;
    logic         inval;
    logic         next_inval;
    logic         rw;
    logic         next_rw;
    // Status and bank values staged until the window closes
    cbct_commit_s commit;
    cbct_commit_s next_commit;
    cbct_commit_s pending;
    cbct_commit_s next_pending;

    // Next-state for the sequencer, hold counter and commit staging
    always_comb begin
        next_state      = state;
        next_cycle      = cycle;
        next_total      = total;
        next_abort_last = abort_last;
        next_hold_cnt   = hold_cnt;
        next_done       = 1'b0;
        next_aborted    = 1'b0;
        next_xbyte      = xbyte;
        next_inval      = inval;
        next_rw         = 1'b1;
        next_commit     = commit;
        next_pending    = pending;
        case (state)
            CBCT_IDLE: begin
                if (start_i) begin
                    // Counts, flags and staged state are all captured at the take
                    next_state      = CBCT_RUN;
                    next_cycle      = 5'h01;
                    next_total      = adj_total;
                    next_abort_last = instr_i.abort_cycle;
                    next_xbyte      = adj_extra_byte;
                    next_inval      = adj_invalid;
                    next_pending    = new_state_i;
                    next_rw         = ~write_cycle_i;
                end
            end
            CBCT_RUN: begin
                // Write level only while the current bus cycle is a write
                next_rw = ~write_cycle_i;
                // Abort outranks the wait hold and cancels the whole instruction
                if (abort_s && cycle <= {3'h0, abort_last}) begin
                    // Cancelled before the bank and status registers move
                    next_state   = CBCT_IDLE;
                    next_aborted = 1'b1;
                    next_cycle   = 5'h00;
                    next_rw      = 1'b1;
                end else if (waiting_i && int_s && cycle == 5'h02) begin
                    next_state    = CBCT_HOLD;
                    next_hold_cnt = CBCT_WAIT_HOLD;
                end else begin
                    // Window closes here: staged status and banks go live
                    if (cycle == {3'h0, abort_last}) begin
                        next_commit = pending;
                    end
                    // Last cycle: back to read level so no stray write follows
                    if (cycle >= total) begin
                        next_state = CBCT_IDLE;
                        next_done  = 1'b1;
                        next_cycle = 5'h00;
                        next_rw    = 1'b1;
                    end else begin
                        next_cycle = cycle + 5'h01;
                    end
                end
            end
            CBCT_HOLD: begin
                // Stays at cycle two for the two extra cycles
                // Abort is not looked at while held; it is seen again from cycle three
                next_rw       = 1'b1;
                next_hold_cnt = hold_cnt - CBCT_ONE_CYCLE;
                if (hold_cnt == CBCT_ONE_CYCLE) begin
                    next_state = CBCT_RUN;
                    next_cycle = 5'h03;
                end
            end
            default: begin
                next_state = CBCT_IDLE;
            end
        endcase
        // Busy is registered from the state it will be in
        next_busy = (next_state != CBCT_IDLE);
    end

    // Registers; reset keeps read level so no stack write happens
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state      <= CBCT_IDLE;
            busy       <= 1'b0;
            cycle      <= 5'h00;
            total      <= 5'h00;
            abort_last <= 2'h0;
            hold_cnt   <= CBCT_BASE_RESET;
            done       <= 1'b0;
            aborted    <= 1'b0;
            xbyte      <= 1'b0;
            inval      <= 1'b0;
            rw         <= 1'b1;
            commit     <= '0;
            pending    <= '0;
        end else begin
            state      <= next_state;
            busy       <= next_busy;
            cycle      <= next_cycle;
            total      <= next_total;
            abort_last <= next_abort_last;
            hold_cnt   <= next_hold_cnt;
            done       <= next_done;
            aborted    <= next_aborted;
            xbyte      <= next_xbyte;
            inval      <= next_inval;
            rw         <= next_rw;
            commit     <= next_commit;
            pending    <= next_pending;
        end
    end

    // ********************************************************************
    // Outputs
    // ********************************************************************
    // Every output is a plain copy of a register
    // Block-move direction is left to software; nothing here checks it
    // Total stands until the next take so a slow reader still sees it
    always_comb begin
        busy_o         = busy;
        done_o         = done;
        aborted_o      = aborted;
        extra_byte_o   = xbyte;
        invalid_addr_o = inval;
        read_write_o   = rw;
        cycle_o        = cycle;
        total_o        = total;
        committed_o    = commit;
    end

endmodule
`default_nettype wire

// file: testbench/cbct_cycle_timing_asserts.sv
`timescale 1ns/1ns
`default_nettype none
// ********************************************************************
// Cycle sequencing checks on the top ports
// ********************************************************************
module cbct_cycle_timing_chk
    import cbct_pkg::*;
(
    input  wire logic         mclk_i,
    input  wire logic         rst_n_i,
    input  wire logic         start_i,
    input  wire logic         busy_o,
    input  wire logic         done_o,
    input  wire logic         aborted_o,
    input  wire logic         read_write_o,
    input  wire logic [4:0]   cycle_o,
    input  wire logic [4:0]   total_o,
    input  wire cbct_commit_s committed_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    // Reset is not a disable here: the read level must hold while it is low
    AST_RESET_READ: assert property (disable iff (1'b0) !rst_n_i |=> read_write_o)
        else $error("write level during reset");
    AST_TAKE: assert property (start_i && !busy_o |=> busy_o && cycle_o == 5'h01)
        else $error("start not taken");
    AST_STEP: assert property (busy_o && cycle_o != 5'h02 && cycle_o < total_o
        |=> !busy_o || cycle_o == $past(cycle_o) + 5'h01) else $error("cycle did not advance");
    AST_HOLD: assert property ((busy_o && cycle_o == 5'h02)[*3] |=> cycle_o != 5'h02)
        else $error("wait hold too long");
    AST_DONE: assert property (done_o |-> $past(cycle_o) == $past(total_o) && !busy_o)
        else $error("done before last cycle");
    AST_END: assert property (busy_o && cycle_o == total_o && cycle_o != 5'h02
        |=> done_o || aborted_o) else $error("last cycle overran");
    AST_ABORT: assert property (aborted_o |-> !busy_o && !done_o && cycle_o == 5'h00)
        else $error("abort left sequence running");
    AST_COMMIT: assert property ($past(rst_n_i) && $changed(committed_o)
        |-> $past(busy_o) && !aborted_o) else $error("commit outside sequence");
    AST_TOTAL: assert property (busy_o && $past(busy_o) |-> $stable(total_o))
        else $error("total changed mid instruction");
endmodule
`default_nettype wire

// file: testbench/cbct_bus_model.sv
`timescale 1ns/1ns
`default_nettype none
// ********************************************************************
// Memory and peripherals on the processor bus
// ********************************************************************
module cbct_bus_model (
    input  wire logic       mclk_i,
    input  wire logic       read_write_i,
    input  wire logic [1:0] int_req_i,
    input  wire logic       write_req_i,
    output var  logic       write_cycle_o,
    output var  logic       irq_o,
    output var  logic       nmi_o,
    output var  int         writes_o
);
    // The test's script of the instruction says which bus cycles are writes
    assign write_cycle_o = write_req_i;
    initial begin
        irq_o    = 1'b0;
        nmi_o    = 1'b0;
        writes_o = 0;
    end
    // Peripheral lines change only after an edge; memory counts write strobes
    always @(posedge mclk_i) begin
        irq_o <= int_req_i[0];
        nmi_o <= int_req_i[1];
        if (!read_write_i) begin
            writes_o <= writes_o + 1;
        end
    end
endmodule
`default_nettype wire

// file: testbench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench
    import cbct_pkg::*;
;
    logic         mclk_i = 1'b0;
    logic         rst_n_i = 1'b0;
    logic         start_i = 1'b0;
    logic         waiting_i = 1'b0;
    logic         abort_pin_i = 1'b0;
    logic         ab_req = 1'b0;
    logic [1:0]   ac = 2'h0;
    logic [2:0]   md = 3'h6;   // Acc 8-bit, index 8-bit, native mode
    logic [7:0]   dl = 8'h00;
    logic [1:0]   int_req = 2'h0;
    logic         write_req = 1'b0;
    cbct_instr_s  instr = '0;
    cbct_commit_s new_state = '0;
    logic         busy_o, done_o, aborted_o, extra_byte_o, invalid_addr_o, read_write_o;
    logic         write_cycle, irq, nmi;
    logic [4:0]   cycle_o, total_o;
    cbct_commit_s committed_o;
    int           mismatches = 0;
    int           tests_run = 0;
    int           cycles = 0;
    int           k;
    int           writes;
    int           wr_seen = 0;

    always #25 mclk_i = ~mclk_i;

    cbct_cycle_timing cbct_cycle_timing_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .start_i(start_i), .instr_i(instr), .acc_width_8_i(md[2]), .index_width_8_i(md[1]),
        .emulation_i(md[0]), .direct_base_low_byte_i(dl), .waiting_i(waiting_i),
        .abort_pin_i(abort_pin_i), .nmi_pin_i(nmi), .irq_pin_i(irq),
        .write_cycle_i(write_cycle), .new_state_i(new_state), .busy_o(busy_o),
        .done_o(done_o), .aborted_o(aborted_o), .extra_byte_o(extra_byte_o),
        .invalid_addr_o(invalid_addr_o), .read_write_o(read_write_o), .cycle_o(cycle_o),
        .total_o(total_o), .committed_o(committed_o));
    cbct_bus_model cbct_bus_model_i (.mclk_i(mclk_i), .read_write_i(read_write_o),
        .int_req_i(int_req), .write_req_i(write_req), .write_cycle_o(write_cycle),
        .irq_o(irq), .nmi_o(nmi), .writes_o(writes));

    task automatic close_out();
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // One instruction; edges from the take to done are counted, bounded
    task automatic run(input cbct_class_e cls, input logic [3:0] base, input logic [4:0] fl,
                       input logic [2:0] mode, input logic [7:0] low, input logic [4:0] exp,
                       input logic [4:0] ek);
        @(negedge mclk_i);
        instr = {cls, base, fl, ac};
        md = mode;
        dl = low;
        abort_pin_i = ab_req;
        start_i = 1'b1;
        @(posedge mclk_i);
        @(negedge mclk_i);
        start_i = 1'b0;
        abort_pin_i = 1'b0;
        k = 1; // The take edge counts as the first
        while (!done_o && !aborted_o && k < 40) begin
            @(posedge mclk_i);
            #1;
            k++;
        end
        // Leave on a falling edge so the caller's next changes stay off the clock
        @(negedge mclk_i);
        if (!aborted_o) check(24'(k), 24'(ek));
        check(24'(total_o), 24'(exp));
    endtask

    // Hang guard: far above the fewer than two hundred cycles the sequence needs
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            close_out();
        end
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (6) @(negedge mclk_i);
        check(24'(read_write_o), 24'h1);
        rst_n_i = 1'b1;
        run(CBCT_CLS_IMMEDIATE, 4'h2, 5'h10, 3'h2, 8'h00, 5'h03, 5'h04);
        check(24'({extra_byte_o, invalid_addr_o}), 24'h2);
        run(CBCT_CLS_IMMEDIATE, 4'h2, 5'h08, 3'h4, 8'h00, 5'h03, 5'h04);
        run(CBCT_CLS_IMMEDIATE, 4'h2, 5'h10, 3'h6, 8'h00, 5'h02, 5'h03);
        check(24'(extra_byte_o), 24'h0);
        run(CBCT_CLS_DIRECT, 4'h3, 5'h00, 3'h6, 8'h00, 5'h03, 5'h04);
        run(CBCT_CLS_DIRECT, 4'h3, 5'h00, 3'h6, 8'h01, 5'h04, 5'h05);
        run(CBCT_CLS_DIRECT, 4'h3, 5'h00, 3'h6, 8'hFF, 5'h04, 5'h05);
        run(CBCT_CLS_ABS_INDEXED, 4'h4, 5'h02, 3'h6, 8'h00, 5'h05, 5'h06);
        check(24'(invalid_addr_o), 24'h1);
        run(CBCT_CLS_ABS_INDEXED, 4'h4, 5'h04, 3'h6, 8'h00, 5'h05, 5'h06);
        run(CBCT_CLS_ABS_INDEXED, 4'h4, 5'h00, 3'h4, 8'h00, 5'h05, 5'h06);
        check(24'(invalid_addr_o), 24'h0);
        run(CBCT_CLS_ABS_INDEXED, 4'h4, 5'h02, 3'h5, 8'h00, 5'h05, 5'h06);
        check(24'(invalid_addr_o), 24'h1);
        run(CBCT_CLS_ABS_INDEXED, 4'h4, 5'h00, 3'h6, 8'h00, 5'h04, 5'h05);
        run(CBCT_CLS_BRANCH, 4'h2, 5'h00, 3'h6, 8'h00, 5'h02, 5'h03);
        run(CBCT_CLS_BRANCH, 4'h2, 5'h01, 3'h6, 8'h00, 5'h03, 5'h04);
        run(CBCT_CLS_BRANCH, 4'h2, 5'h03, 3'h6, 8'h00, 5'h03, 5'h04);
        run(CBCT_CLS_BRANCH, 4'h2, 5'h03, 3'h7, 8'h00, 5'h04, 5'h05);
        run(CBCT_CLS_BRANCH, 4'h2, 5'h02, 3'h7, 8'h00, 5'h02, 5'h03);
        run(CBCT_CLS_INTERRUPT, 4'h8, 5'h00, 3'h6, 8'h00, 5'h08, 5'h09);
        run(CBCT_CLS_INTERRUPT, 4'h8, 5'h00, 3'h7, 8'h00, 5'h07, 5'h08);
        run(CBCT_CLS_STATUS_OP, 4'h2, 5'h00, 3'h6, 8'h00, 5'h03, 5'h04);
        run(CBCT_CLS_BLOCK_MOVE, 4'h7, 5'h00, 3'h6, 8'h00, 5'h07, 5'h08);
        // Maskable then non-maskable request while waiting
        waiting_i = 1'b1;
        for (int j = 1; j < 3; j++) begin
            int_req = 2'(j);
            repeat (3) @(negedge mclk_i);
            run(CBCT_CLS_OTHER, 4'h4, 5'h00, 3'h6, 8'h00, 5'h04, 5'h07);
        end
        int_req = 2'h0;
        waiting_i = 1'b0;
        // Abort inside the window must leave committed state untouched
        new_state = 24'hA51234;
        ac = 2'h3;
        ab_req = 1'b1;
        run(CBCT_CLS_OTHER, 4'h6, 5'h00, 3'h6, 8'h00, 5'h06, 5'h07);
        check(24'(aborted_o), 24'h1);
        check(24'(committed_o), 24'h0);
        ab_req = 1'b0;
        run(CBCT_CLS_OTHER, 4'h6, 5'h00, 3'h6, 8'h00, 5'h06, 5'h07);
        check(24'(committed_o), 24'hA51234);
        // Reset arriving in mid instruction while a write cycle is on the bus
        write_req = 1'b1;
        start_i = 1'b1;
        @(negedge mclk_i);
        start_i = 1'b0;
        check(24'(read_write_o), 24'h0);
        @(negedge mclk_i);
        rst_n_i = 1'b0;
        @(negedge mclk_i);
        wr_seen = writes;
        @(negedge mclk_i);
        check(24'({read_write_o, busy_o, cycle_o}), 24'h40);
        rst_n_i = 1'b1;
        write_req = 1'b0;
        repeat (2) @(negedge mclk_i);
        check(24'(writes), 24'(wr_seen));
        close_out();
    end
endmodule

bind cbct_cycle_timing cbct_cycle_timing_chk cbct_cycle_timing_chk_i (.mclk_i(mclk_i),
    .rst_n_i(rst_n_i), .start_i(start_i), .busy_o(busy_o), .done_o(done_o),
    .aborted_o(aborted_o), .read_write_o(read_write_o), .cycle_o(cycle_o),
    .total_o(total_o), .committed_o(committed_o));
`default_nettype wire
